// File: deser_cfg_pkg.sv
// constants shared by the deserializer reset and general configuration bank
// assumes the register port and the strap sampler run on the 10 MHz mclk
`default_nettype none
package deser_cfg_pkg;

  // register offsets on the register port
  localparam logic [7:0] bus_target_address_off = 8'h00;
  localparam logic [7:0] soft_reset_control_off = 8'h01;
  localparam logic [7:0] general_output_config_off = 8'h02;

  // field positions
  localparam int address_source_select_pos = 0;
  localparam int logic_only_soft_reset_pos = 0;
  localparam int full_soft_reset_pos = 1;
  localparam int unlocked_state_select_pos = 4;
  localparam int fallback_clock_output_enable_pos = 5;
  localparam int output_override_pos = 6;
  localparam int output_enable_value_pos = 7;

  // values after reset
  localparam logic [7:0] soft_reset_control_rst = 8'h04;
  localparam logic [7:0] general_output_config_rst = 8'h80;
  localparam logic [6:0] bus_target_address_field_rst = 7'h00;
  localparam logic address_source_select_rst = 1'b0;
  localparam logic [7:0] unmapped_read_value = 8'h00;

  // soft reset pulse length
  localparam int clock_period_ns = 100;
  localparam int soft_reset_hold_ns = 800;
  localparam int soft_reset_hold_cycles =
    (soft_reset_hold_ns + clock_period_ns - 1) / clock_period_ns;
  localparam logic [3:0] soft_reset_hold_count = 4'(soft_reset_hold_cycles - 1);

  // strap sampling waits this many cycles after reset release
  localparam logic [1:0] strap_settle_count = 2'h2;

  // soft reset sequencer states
  typedef enum logic [2:0] {
    seq_idle = 3'b001,
    seq_full = 3'b010,
    seq_logic = 3'b100
  } soft_reset_state_type;

endpackage
`default_nettype wire

// File: strap_capture.sv
// samples the address strap pin once after power-on reset
// assumes the strap input is static after power-up but asynchronous to mclk
`timescale 1ns/1ns
`default_nettype none
module strap_capture
  import deser_cfg_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // strap pin
  input wire logic [6:0] address_strap_pin,
  // captured value
  output logic [6:0] strap_address,
  output logic strap_load
);

  logic [6:0] strap_meta_reg; // first synchroniser stage
  logic [6:0] strap_sync_reg; // second synchroniser stage
  logic [6:0] strap_address_reg;
  logic [6:0] strap_address_next;
  logic [1:0] settle_reg;
  logic [1:0] settle_next;
  logic done_reg;
  logic done_next;
  logic load_reg;
  logic load_next;

  // next values: wait for the synchroniser to fill, then capture once
  always_comb begin
    settle_next = settle_reg;
    done_next = done_reg;
    load_next = 1'b0;
    strap_address_next = strap_address_reg;
    if (!done_reg) begin
      if (settle_reg == strap_settle_count) begin
        strap_address_next = strap_sync_reg;
        done_next = 1'b1;
        load_next = 1'b1;
      end else begin
        settle_next = settle_reg + 2'h1;
      end
    end
  end

  // registers, only the power-on reset restarts the capture
  always_ff @(posedge mclk) begin
    strap_meta_reg <= address_strap_pin;
    strap_sync_reg <= strap_meta_reg;
    if (rst) begin
      settle_reg <= 2'h0;
      done_reg <= 1'b0;
      load_reg <= 1'b0;
      strap_address_reg <= bus_target_address_field_rst;
    end else begin
      settle_reg <= settle_next;
      done_reg <= done_next;
      load_reg <= load_next;
      strap_address_reg <= strap_address_next;
    end
  end

  assign strap_address = strap_address_reg;
  assign strap_load = load_reg;

endmodule
`default_nettype wire

// File: soft_reset_seq.sv
// stretches a soft reset request into a fixed-length reset pulse
// assumes the request strobes are single-cycle pulses on mclk
`timescale 1ns/1ns
`default_nettype none
module soft_reset_seq
  import deser_cfg_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // requests
  input wire logic full_request,
  input wire logic logic_request,
  // reset outputs
  output logic register_reset,
  output logic logic_reset
);

  soft_reset_state_type state_reg;
  soft_reset_state_type state_next;
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic reg_rst_reg;
  logic reg_rst_next;
  logic logic_rst_reg;
  logic logic_rst_next;

  // next state: full request outranks logic-only request
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      seq_idle: begin
        count_next = soft_reset_hold_count;
        if (full_request) begin
          state_next = seq_full;
        end else if (logic_request) begin
          state_next = seq_logic;
        end
      end
      seq_full, seq_logic: begin
        // a full request during logic reset upgrades it
        if (full_request && state_reg == seq_logic) begin
          state_next = seq_full;
          count_next = soft_reset_hold_count;
        end else if (count_reg == 4'h0) begin
          state_next = seq_idle;
        end else begin
          count_next = count_reg - 4'h1;
        end
      end
      default: begin
        state_next = seq_idle;
        count_next = soft_reset_hold_count;
      end
    endcase
    reg_rst_next = (state_next == seq_full);
    logic_rst_next = (state_next != seq_idle);
  end

  // state registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= seq_idle;
      count_reg <= soft_reset_hold_count;
      reg_rst_reg <= 1'b0;
      logic_rst_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      reg_rst_reg <= reg_rst_next;
      logic_rst_reg <= logic_rst_next;
    end
  end

  assign register_reset = reg_rst_reg;
  assign logic_reset = logic_rst_reg;

endmodule
`default_nettype wire

// File: deser_reset_general_config.sv
// register bank for target address, soft resets and unlocked output control
// assumes the serial bus front end decodes transfers into the register port
// on mclk, and that lock and strap arrive from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module deser_reset_general_config
  import deser_cfg_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port from the serial bus front end
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // strap and link status pins
  input wire logic [6:0] address_strap_pin,
  input wire logic link_lock,
  // serial bus address used by the front end
  output logic [6:0] bus_target_address,
  // resets to the rest of the digital block
  output logic logic_reset,
  output logic register_reset,
  // output control
  output logic output_enable,
  output logic unlocked_sleep,
  output logic outputs_active,
  output logic fallback_clock_select
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // pick the programmed value under override, else the fixed default of one
  function automatic logic override_value(input logic ovr, input logic value);
    override_value = ovr ? value : 1'b1;
  endfunction

  // true when a write strobe hits the given offset
  function automatic logic write_hit(input logic wr, input logic [7:0] addr,
                                     input logic [7:0] off);
    write_hit = wr && (addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [6:0] strap_address; // address caught from the strap after power-on
  logic strap_load; // one-cycle pulse when the strap capture completes
  logic soft_reg_reset; // register reset from the full soft reset
  logic soft_logic_reset; // logic reset from either soft reset
  logic full_request; // write of one to the full reset bit
  logic logic_request; // write of one to the logic-only reset bit
  logic bank_reset; // clears the register contents
  logic core_reset; // clears the non-register logic

  // register contents
  logic [6:0] addr_field_reg;
  logic [6:0] addr_field_next;
  logic addr_src_reg;
  logic addr_src_next;
  logic [5:0] rst_reserved_reg; // bits 7:2 of the reset register
  logic [5:0] rst_reserved_next;
  logic [7:0] gen_cfg_reg;
  logic [7:0] gen_cfg_next;

  // read port
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  // lock synchroniser
  logic lock_meta_reg; // first stage, read only by the second
  logic lock_sync_reg;

  // registered outputs
  logic [6:0] bus_addr_reg;
  logic [6:0] bus_addr_next;
  logic oe_reg;
  logic oe_next;
  logic sleep_reg;
  logic sleep_next;
  logic active_reg;
  logic active_next;
  logic fallback_reg;
  logic fallback_next;

  ////////////////////////////////////////////////////////////////////////////
  // submodules

  // strap sampler for the default target address
  strap_capture u_strap (
    .mclk(mclk),
    .rst(rst),
    .address_strap_pin(address_strap_pin),
    .strap_address(strap_address),
    .strap_load(strap_load)
  );

  // soft reset pulse generator
  soft_reset_seq u_seq (
    .mclk(mclk),
    .rst(rst),
    .full_request(full_request),
    .logic_request(logic_request),
    .register_reset(soft_reg_reset),
    .logic_reset(soft_logic_reset)
  );

  ////////////////////////////////////////////////////////////////////////////
  // soft reset requests

  // a write of one to a self-clearing bit only raises a request
  always_comb begin
    full_request = write_hit(reg_wr, reg_addr, soft_reset_control_off)
                   && reg_wdata[full_soft_reset_pos];
    logic_request = write_hit(reg_wr, reg_addr, soft_reset_control_off)
                    && reg_wdata[logic_only_soft_reset_pos];
    bank_reset = rst || soft_reg_reset;
    core_reset = rst || soft_logic_reset;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register contents

  // next values of the stored fields
  always_comb begin
    addr_field_next = addr_field_reg;
    addr_src_next = addr_src_reg;
    rst_reserved_next = rst_reserved_reg;
    gen_cfg_next = gen_cfg_reg;
    // strap value lands after power-on, and again on a full soft reset
    if (strap_load || soft_reg_reset) begin
      addr_field_next = strap_address;
    end else if (write_hit(reg_wr, reg_addr, bus_target_address_off)) begin
      // software overrides the strapped address
      addr_field_next = reg_wdata[7:1];
      addr_src_next = reg_wdata[address_source_select_pos];
    end
    if (write_hit(reg_wr, reg_addr, soft_reset_control_off)) begin
      // reserved bits keep what software writes, reset bits are not stored
      rst_reserved_next = reg_wdata[7:2];
    end
    if (write_hit(reg_wr, reg_addr, general_output_config_off)) begin
      gen_cfg_next = reg_wdata;
    end
  end

  // register contents clear on power-on or full soft reset, not logic reset
  always_ff @(posedge mclk) begin
    if (bank_reset) begin
      addr_field_reg <= soft_reg_reset ? strap_address : bus_target_address_field_rst;
      addr_src_reg <= address_source_select_rst;
      rst_reserved_reg <= soft_reset_control_rst[7:2];
      gen_cfg_reg <= general_output_config_rst;
    end else begin
      addr_field_reg <= addr_field_next;
      addr_src_reg <= addr_src_next;
      rst_reserved_reg <= rst_reserved_next;
      gen_cfg_reg <= gen_cfg_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  // read data one cycle after the strobe, unmapped offsets read zero
  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        bus_target_address_off: begin
          rdata_next = {addr_field_reg, addr_src_reg};
        end
        soft_reset_control_off: begin
          // self-clearing bits always read back as zero
          rdata_next = {rst_reserved_reg, 2'b00};
        end
        general_output_config_off: begin
          rdata_next = gen_cfg_reg;
        end
        default: begin
          rdata_next = unmapped_read_value;
        end
      endcase
    end
  end

  // read registers belong to the logic, not the register contents
  always_ff @(posedge mclk) begin
    if (core_reset) begin
      rdata_reg <= unmapped_read_value;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock synchroniser

  // two stages before anything looks at lock
  always_ff @(posedge mclk) begin
    if (core_reset) begin
      lock_meta_reg <= 1'b0;
      lock_sync_reg <= 1'b0;
    end else begin
      lock_meta_reg <= link_lock;
      lock_sync_reg <= lock_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output control

  // effective address, enable, sleep state and fallback clock choice
  always_comb begin
    if (addr_src_reg) begin
      bus_addr_next = addr_field_reg;
    end else begin
      bus_addr_next = strap_address;
    end
    oe_next = override_value(gen_cfg_reg[output_override_pos],
                             gen_cfg_reg[output_enable_value_pos]);
    sleep_next = override_value(gen_cfg_reg[output_override_pos],
                                gen_cfg_reg[unlocked_state_select_pos]);
    // while locked the enable alone decides, while unlocked sleep also counts
    if (lock_sync_reg) begin
      active_next = oe_next;
    end else begin
      active_next = oe_next && !sleep_next;
    end
    // oscillator clock replaces the recovered clock only when unlocked
    fallback_next = gen_cfg_reg[fallback_clock_output_enable_pos]
                    && !lock_sync_reg;
  end

  // output registers, quiet during any reset
  always_ff @(posedge mclk) begin
    if (core_reset) begin
      bus_addr_reg <= bus_target_address_field_rst;
      oe_reg <= 1'b1;
      sleep_reg <= 1'b1;
      active_reg <= 1'b0;
      fallback_reg <= 1'b0;
    end else begin
      bus_addr_reg <= bus_addr_next;
      oe_reg <= oe_next;
      sleep_reg <= sleep_next;
      active_reg <= active_next;
      fallback_reg <= fallback_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port drives

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign bus_target_address = bus_addr_reg;
  assign logic_reset = soft_logic_reset;
  assign register_reset = soft_reg_reset;
  assign output_enable = oe_reg;
  assign unlocked_sleep = sleep_reg;
  assign outputs_active = active_reg;
  assign fallback_clock_select = fallback_reg;

endmodule
`default_nettype wire

// File: deser_cfg_props.sv
// checker for the reset and output configuration bank
// assumes it watches the top module ports only, bound below
`timescale 1ns/1ns
`default_nettype none
module deser_cfg_props
  import deser_cfg_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // pins and outputs
  input wire logic [6:0] address_strap_pin,
  input wire logic link_lock,
  input wire logic [6:0] bus_target_address,
  input wire logic logic_reset,
  input wire logic register_reset,
  input wire logic output_enable,
  input wire logic unlocked_sleep,
  input wire logic outputs_active,
  input wire logic fallback_clock_select
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // cycles since any reset ended, saturating
  logic [2:0] quiet_reg;
  logic [2:0] quiet_next;
  // write strobes to each mapped register
  logic wr_rst;
  logic wr_cfg;
  logic wr_id;
  assign wr_rst = reg_wr && reg_addr == soft_reset_control_off;
  assign wr_cfg = reg_wr && reg_addr == general_output_config_off && !logic_reset;
  // the strap load three edges after release wins over a software write
  assign wr_id = reg_wr && reg_addr == bus_target_address_off && !logic_reset
    && quiet_reg != 3'h3;
  // next quiet count: cleared by any reset
  always_comb begin
    quiet_next = quiet_reg;
    if (rst || logic_reset) begin
      quiet_next = 3'h0;
    end else if (quiet_reg != 3'h7) begin
      quiet_next = quiet_reg + 3'h1;
    end
  end
  // quiet count register
  always_ff @(posedge mclk) begin
    quiet_reg <= quiet_next;
  end
////////////////////////////////////////////////////////////
  chk_read_answer: assert property (reg_rd && !reg_wr && !logic_reset |=> reg_rvalid)
    else $error("read not answered next cycle");
  chk_quiet_reads: assert property (logic_reset && $past(logic_reset) |-> !reg_rvalid)
    else $error("read answered during soft reset");
  chk_full_launch: assert property (wr_rst && reg_wdata[1] && !register_reset
    |=> register_reset && logic_reset)
    else $error("full soft reset not launched");
  chk_logic_launch: assert property (wr_rst && reg_wdata[0] && !logic_reset |=> logic_reset)
    else $error("logic soft reset not launched");
  chk_logic_length: assert property ($rose(logic_reset)
    |-> logic_reset [*8] ##1 (!logic_reset || register_reset))
    else $error("logic reset pulse length wrong");
  chk_full_length: assert property ($rose(register_reset)
    |-> register_reset [*8] ##1 !register_reset)
    else $error("full reset pulse length wrong");
  chk_full_covers: assert property (register_reset |-> logic_reset)
    else $error("full reset without logic reset");
  chk_default_outputs: assert property (wr_cfg && !reg_wdata[6]
    |-> ##2 output_enable && unlocked_sleep)
    else $error("default enable or sleep not applied");
  chk_override_values: assert property (wr_cfg && reg_wdata[6] |-> ##2
    output_enable == $past(reg_wdata[7], 2) && unlocked_sleep == $past(reg_wdata[4], 2))
    else $error("override values not applied");
  chk_address_source: assert property (wr_id && reg_wdata[0]
    |-> ##2 bus_target_address == $past(reg_wdata[7:1], 2))
    else $error("programmed address not used");
  chk_fallback_lock: assert property (fallback_clock_select && quiet_reg >= 3'h5
    |-> !$past(link_lock, 3))
    else $error("fallback clock while locked");
endmodule
bind deser_reset_general_config deser_cfg_props i_deser_cfg_props (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .address_strap_pin(address_strap_pin), .link_lock(link_lock),
  .bus_target_address(bus_target_address), .logic_reset(logic_reset),
  .register_reset(register_reset), .output_enable(output_enable),
  .unlocked_sleep(unlocked_sleep), .outputs_active(outputs_active),
  .fallback_clock_select(fallback_clock_select));
`default_nettype wire

// File: cfg_host_model.sv
// host model driving the register port of the bank
// assumes one strobe per sampled edge and read answers one cycle later
`timescale 1ns/1ns
`default_nettype none
module cfg_host_model
  import deser_cfg_pkg::*;
(
  // clock
  input wire logic mclk,
  // register port towards the bank
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // half a millisecond at 10 MHz
  localparam int settle_cycles = 5000;
  // idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
////////////////////////////////////////////////////////////
  // one write, strobe held across the sampling edge
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;  // released data no longer valid
  endtask
  // one read, answer taken when it has settled
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    ok = reg_rvalid;
    d = reg_rdata;
  endtask
  // logic-only soft reset with the host duties around it
  task automatic logic_reset_seq();
    write(8'h6c, 8'hff);
    write(soft_reset_control_off, 8'h05);
    repeat (settle_cycles) @(posedge mclk);
  endtask
  // raising the programmed enable is followed by a logic reset
  task automatic raise_enable();
    write(general_output_config_off, 8'hc0);
    logic_reset_seq();
  endtask
endmodule
`default_nettype wire

// File: tb_deser_reset_general_config.sv
// testbench for the reset and output configuration bank
// assumes the host model drives the register port
`timescale 1ns/1ns
`default_nettype none
module tb_deser_reset_general_config;
  import deser_cfg_pkg::*;
  // table row: write, then expected readback and outputs
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] rexp;
    logic oe;
    logic sleep;
  } row_type;
  logic mclk;
  logic rst;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [6:0] address_strap_pin;
  logic link_lock;
  logic [6:0] bus_target_address;
  logic logic_reset;
  logic register_reset;
  logic output_enable;
  logic unlocked_sleep;
  logic outputs_active;
  logic fallback_clock_select;
  int errors;
  int checks_done;
  logic [7:0] rd_data;
  logic rd_ok;
  row_type rows [8];
  // design under test
  deser_reset_general_config i_deser_reset_general_config (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .address_strap_pin(address_strap_pin), .link_lock(link_lock),
    .bus_target_address(bus_target_address), .logic_reset(logic_reset),
    .register_reset(register_reset), .output_enable(output_enable),
    .unlocked_sleep(unlocked_sleep), .outputs_active(outputs_active),
    .fallback_clock_select(fallback_clock_select));
  // host on the register port
  cfg_host_model i_cfg_host_model (
    .mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  // 10 MHz clock
  always #50 mclk = ~mclk;
////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // read one register and compare
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    i_cfg_host_model.read(a, d, ok);
    check({7'h00, ok}, 8'h01, "read valid");
    check(d, exp, "read data");
  endtask
  // verdict and end of run
  task automatic summarize();
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // watchdog well past the expected run
  initial begin
    #(20000 * 100);
    errors++;
    $display("[FAIL] %0t run did not finish", $time);
    summarize();
  end
////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    address_strap_pin = 7'h2a;
    link_lock = 1'b1;
    errors = 0;
    checks_done = 0;
    rows[0] = {8'h02, 8'hff, 8'hff, 1'b1, 1'b1};
    rows[1] = {8'h02, 8'h40, 8'h40, 1'b0, 1'b0};
    rows[2] = {8'h02, 8'h50, 8'h50, 1'b0, 1'b1};
    rows[3] = {8'h02, 8'h80, 8'h80, 1'b1, 1'b1};
    rows[4] = {8'h02, 8'h0f, 8'h0f, 1'b1, 1'b1};
    rows[5] = {8'h00, 8'hab, 8'hab, 1'b1, 1'b1};
    rows[6] = {8'h01, 8'hf8, 8'hf8, 1'b1, 1'b1};
    rows[7] = {8'h6c, 8'hff, 8'h00, 1'b1, 1'b1};
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
    // values after power-on reset
    rdchk(bus_target_address_off, {7'h2a, 1'b0});
    check({1'b0, bus_target_address}, 8'h2a, "strap address");
    rdchk(soft_reset_control_off, soft_reset_control_rst);
    rdchk(general_output_config_off, general_output_config_rst);
    check({6'h00, output_enable, unlocked_sleep}, 8'h03, "default outputs");
    // ordinary writes with readback and outputs
    foreach (rows[i]) begin
      i_cfg_host_model.write(rows[i].addr, rows[i].data);
      rdchk(rows[i].addr, rows[i].rexp);
      check({6'h00, output_enable, unlocked_sleep}, {6'h00, rows[i].oe, rows[i].sleep},
        "outputs");
    end
    check({1'b0, bus_target_address}, 8'h55, "programmed address");
    // loss of lock with and without override
    i_cfg_host_model.write(general_output_config_off, 8'h20);
    @(posedge mclk);
    link_lock <= 1'b0;
    repeat (5) @(posedge mclk);
    check({7'h00, fallback_clock_select}, 8'h01, "fallback on");
    check({7'h00, outputs_active}, 8'h00, "asleep unlocked");
    i_cfg_host_model.write(general_output_config_off, 8'he0);
    repeat (3) @(posedge mclk);
    check({7'h00, outputs_active}, 8'h01, "awake unlocked");
    link_lock <= 1'b1;
    repeat (5) @(posedge mclk);
    check({6'h00, fallback_clock_select, outputs_active}, 8'h01, "locked");
    // logic-only reset keeps registers
    i_cfg_host_model.raise_enable();
    rdchk(bus_target_address_off, 8'hab);
    rdchk(soft_reset_control_off, 8'h04);
    rdchk(general_output_config_off, 8'hc0);
    // full reset restores strap and defaults
    i_cfg_host_model.write(general_output_config_off, 8'h40);
    i_cfg_host_model.write(soft_reset_control_off, 8'h06);
    // a read inside the pulse gets no answer
    i_cfg_host_model.read(general_output_config_off, rd_data, rd_ok);
    check({7'h00, rd_ok}, 8'h00, "read during reset");
    check({6'h00, register_reset, logic_reset}, 8'h03, "full reset pulse");
    repeat (10) @(posedge mclk);
    check({6'h00, register_reset, logic_reset}, 8'h00, "full reset ended");
    rdchk(bus_target_address_off, {7'h2a, 1'b0});
    check({1'b0, bus_target_address}, 8'h2a, "strap restored");
    rdchk(soft_reset_control_off, soft_reset_control_rst);
    rdchk(general_output_config_off, general_output_config_rst);
    check({7'h00, output_enable}, 8'h01, "enable restored");
    // power-on reset in mid-run drops the programmed address and recaptures the strap
    i_cfg_host_model.write(bus_target_address_off, 8'h33);
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
    rdchk(bus_target_address_off, {7'h2a, 1'b0});
    check({1'b0, bus_target_address}, 8'h2a, "strap after reset");
    rdchk(general_output_config_off, general_output_config_rst);
    summarize();
  end
endmodule
`default_nettype wire
